/* File: gdam_consts.svh */
`ifndef GDAM_CONSTS_SVH
`define GDAM_CONSTS_SVH

// register offsets on the serial register port
`define GDAM_OFS_PIN_CFG 8'h1b
`define GDAM_OFS_PIN_DATA 8'h1c
`define GDAM_OFS_ALARM_MASK 8'h1d

// pin count and register width
`define GDAM_NUM_PINS 7
`define GDAM_REG_W 16
`define GDAM_ADDR_W 8

// reset values
`define GDAM_RST_PIN_DATA 16'h007f
`define GDAM_RST_ALARM_MASK 16'hefdf
`define GDAM_RST_CFG_EN 7'h00
`define GDAM_RST_CFG_ODE 7'h7f

// pin configuration field positions
`define GDAM_CFG_EN_LSB 8
`define GDAM_CFG_ODE_LSB 0

// alarm mask layout: writable bits and reserved bits that read as one
`define GDAM_MASK_WR_BITS 16'h31ff
`define GDAM_MASK_RSV_ONES 16'hce00

// alarm mask bit positions
`define GDAM_BIT_SHUTDOWN 13
`define GDAM_BIT_OSCILLATOR_FAILURE_MASK 12
`define GDAM_BIT_OTP_CHECKSUM 8
`define GDAM_BIT_SERIAL_CHECKSUM 7
`define GDAM_BIT_WATCHDOG 6
`define GDAM_BIT_REFERENCE 5
`define GDAM_BIT_INPUT_ONE 4
`define GDAM_BIT_INPUT_ZERO 3
`define GDAM_BIT_CONV_TEMP 2
`define GDAM_BIT_OVERHEAT_ERR 1
`define GDAM_BIT_OVERHEAT_WARN 0

`endif

/* File: gdam_pkg.sv */
package gdam_pkg;

    // one access from the serial register port decoder
    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } gdam_reg_req_t;

    // drive of the seven general purpose pins
    typedef struct packed {
        logic [6:0] level;
        logic [6:0] oe_n;
    } gdam_pin_drv_t;

endpackage

/* File: gdam_regs.sv */
`timescale 1ns/10ps
`include "gdam_consts.svh"
// Behaviour
// - the pin data register sits at 1Ch, resets to 007Fh, bits 6..0 are pins 6..0, 15..7 read 0.
// - for a pin set up as an input, a read of the pin data register returns the live pin level.
// - for an output pin, the written data bit sets the level the device drives.
// - the alarm mask sits at 1Dh, resets to EFDFh, bits 15..14 read 3h and bits 11..9 read 7h.
// - a mask bit at 0 lets its fault raise the interrupt request.
// - a mask bit at 1 blocks its fault from both interrupt and alarm; default for most bits.
// - fault status bits are set by their conditions whatever the mask holds.
// - oscillator failure mask bit 12 and reference mask bit 5 reset to 0.
// - mask bit 1 gates the over-temperature error above 130 C and resets to 1.
// - mask bit 0 gates the temperature warning above 85 C and resets to 1.
// - a configuration enable bit at 1 turns on the pin function, at 0 leaves it off.
// - an open-drain select bit at 1 gives pseudo open-drain output, at 0 push-pull.

module gdam_regs #(
    parameter int NUM_PINS = `GDAM_NUM_PINS
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // register port from the serial decoder
    input gdam_pkg::gdam_reg_req_t reg_req,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    // general purpose pins
    input wire logic [NUM_PINS-1:0] pin_in,
    output gdam_pkg::gdam_pin_drv_t pin_drv,
    // fault status from the status register, mask layout
    input wire logic [15:0] fault_status,
    output logic [15:0] alarm_mask,
    output logic irq,
    output logic alarm_trigger,
    output logic fault_present
);

    // true when a pin is enabled, open-drain and written high
    function automatic logic pin_is_input(
        input logic en,
        input logic ode,
        input logic data
    );
        pin_is_input = en & ode & data;
    endfunction

    // true when an access targets the given offset
    function automatic logic hit(
        input logic [7:0] addr,
        input logic [7:0] ofs
    );
        hit = (addr == ofs);
    endfunction

    // keeps only the bits that carry a fault or its mask
    function automatic logic [15:0] fault_bits(
        input logic [15:0] v
    );
        fault_bits = v & `GDAM_MASK_WR_BITS;
    endfunction

    // stored register state
    logic [NUM_PINS-1:0] data_r;
    logic [NUM_PINS-1:0] data_nxt;
    logic [NUM_PINS-1:0] cfg_en_r;
    logic [NUM_PINS-1:0] cfg_en_nxt;
    logic [NUM_PINS-1:0] cfg_ode_r;
    logic [NUM_PINS-1:0] cfg_ode_nxt;
    logic [15:0] mask_r;
    logic [15:0] mask_nxt;

    // read path state
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic rvalid_r;
    logic rvalid_nxt;

    // pin synchroniser and filtered level
    logic [NUM_PINS-1:0] sync1_r;
    logic [NUM_PINS-1:0] sync2_r;
    logic [NUM_PINS-1:0] sync3_r;
    logic [NUM_PINS-1:0] sync1_nxt;
    logic [NUM_PINS-1:0] sync2_nxt;
    logic [NUM_PINS-1:0] sync3_nxt;
    logic [NUM_PINS-1:0] lvl_r;
    logic [NUM_PINS-1:0] lvl_nxt;

    // pin drive state
    logic [NUM_PINS-1:0] drv_lvl_r;
    logic [NUM_PINS-1:0] drv_lvl_nxt;
    logic [NUM_PINS-1:0] drv_oe_n_r;
    logic [NUM_PINS-1:0] drv_oe_n_nxt;

    // alarm outputs
    logic irq_r;
    logic irq_nxt;
    logic alarm_r;
    logic alarm_nxt;
    logic present_r;
    logic present_nxt;

    // combined values seen by software
    logic [NUM_PINS-1:0] pin_read;
    logic [15:0] mask_view;
    logic [15:0] cfg_view;
    logic [15:0] unmasked;

    // register writes
    always_comb begin
        data_nxt = data_r;
        cfg_en_nxt = cfg_en_r;
        cfg_ode_nxt = cfg_ode_r;
        mask_nxt = mask_r;
        if (reg_req.wr) begin
            if (hit(reg_req.addr, `GDAM_OFS_PIN_DATA)) begin
                data_nxt = reg_req.wdata[NUM_PINS-1:0];
            end
            if (hit(reg_req.addr, `GDAM_OFS_PIN_CFG)) begin
                cfg_en_nxt = reg_req.wdata[`GDAM_CFG_EN_LSB +: NUM_PINS];
                cfg_ode_nxt = reg_req.wdata[`GDAM_CFG_ODE_LSB +: NUM_PINS];
            end
            if (hit(reg_req.addr, `GDAM_OFS_ALARM_MASK)) begin
                mask_nxt = fault_bits(reg_req.wdata);
            end
        end
    end

    // register storage; mask reset leaves bits 12 and 5 clear
    // pins reset disabled, so nothing is driven until software enables them
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            data_r <= NUM_PINS'(`GDAM_RST_PIN_DATA);
            cfg_en_r <= NUM_PINS'(`GDAM_RST_CFG_EN);
            cfg_ode_r <= NUM_PINS'(`GDAM_RST_CFG_ODE);
            mask_r <= `GDAM_RST_ALARM_MASK & `GDAM_MASK_WR_BITS;
        end else begin
            data_r <= data_nxt;
            cfg_en_r <= cfg_en_nxt;
            cfg_ode_r <= cfg_ode_nxt;
            mask_r <= mask_nxt;
        end
    end

    // three-stage pin synchroniser, next values
    // the first stage may go metastable, so only the second stage reads it
    always_comb begin
        sync1_nxt = pin_in;
        sync2_nxt = sync1_r;
        sync3_nxt = sync2_r;
    end

    // synchroniser stages
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sync1_r <= '0;
            sync2_r <= '0;
            sync3_r <= '0;
        end else begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
            sync3_r <= sync3_nxt;
        end
    end

    // a pin level counts once the second and third stages agree
    // a change seen by one stage only leaves the old level in place
    always_comb begin
        lvl_nxt = lvl_r;
        for (int i = 0; i < NUM_PINS; i++) begin
            if (sync2_r[i] == sync3_r[i]) begin
                lvl_nxt[i] = sync3_r[i];
            end
        end
    end

    // filtered pin level
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            lvl_r <= '0;
        end else begin
            lvl_r <= lvl_nxt;
        end
    end

    // pin drive: off when disabled, pseudo open-drain or push-pull
    // pseudo open-drain never drives high, so an input pin is not fought
    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            drv_lvl_nxt[i] = data_r[i];
            if (!cfg_en_r[i]) begin
                drv_oe_n_nxt[i] = 1'b1;
            end else if (cfg_ode_r[i]) begin
                drv_lvl_nxt[i] = 1'b0;
                drv_oe_n_nxt[i] = data_r[i];
            end else begin
                drv_oe_n_nxt[i] = 1'b0;
            end
        end
    end

    // pin drive registers, released during reset
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            drv_lvl_r <= '0;
            drv_oe_n_r <= '1;
        end else begin
            drv_lvl_r <= drv_lvl_nxt;
            drv_oe_n_r <= drv_oe_n_nxt;
        end
    end

    // data read: live level for inputs, stored bit otherwise
    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            if (pin_is_input(cfg_en_r[i], cfg_ode_r[i], data_r[i])) begin
                pin_read[i] = lvl_r[i];
            end else begin
                pin_read[i] = data_r[i];
            end
        end
    end

    // register views with reserved bits filled in
    always_comb begin
        mask_view = mask_r | `GDAM_MASK_RSV_ONES;
        cfg_view = '0;
        cfg_view[`GDAM_CFG_EN_LSB +: NUM_PINS] = cfg_en_r;
        cfg_view[`GDAM_CFG_ODE_LSB +: NUM_PINS] = cfg_ode_r;
    end

    // read mux; unmapped offsets read zero
    // a read in the same cycle as a write returns the old value
    always_comb begin
        rdata_nxt = rdata_r;
        rvalid_nxt = reg_req.rd;
        if (reg_req.rd) begin
            rdata_nxt = '0;
            unique case (reg_req.addr)
                `GDAM_OFS_PIN_DATA: begin
                    rdata_nxt[NUM_PINS-1:0] = pin_read;
                end
                `GDAM_OFS_ALARM_MASK: begin
                    rdata_nxt = mask_view;
                end
                `GDAM_OFS_PIN_CFG: begin
                    rdata_nxt = cfg_view;
                end
                default: begin
                    rdata_nxt = '0;
                end
            endcase
        end
    end

    // read data registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdata_r <= '0;
            rvalid_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    // faults that the mask lets through
    // reserved status bits never reach the interrupt or the alarm
    always_comb begin
        unmasked = fault_bits(fault_status) & ~mask_r;
    end

    // interrupt, alarm and raw fault summary
    always_comb begin
        irq_nxt = |unmasked;
        alarm_nxt = |unmasked;
        present_nxt = |fault_bits(fault_status);
    end

    // alarm output registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irq_r <= 1'b0;
            alarm_r <= 1'b0;
            present_r <= 1'b0;
        end else begin
            irq_r <= irq_nxt;
            alarm_r <= alarm_nxt;
            present_r <= present_nxt;
        end
    end

    // outputs
    assign reg_rdata = rdata_r;
    assign reg_rvalid = rvalid_r;
    assign pin_drv.level = drv_lvl_r;
    assign pin_drv.oe_n = drv_oe_n_r;
    assign alarm_mask = mask_view;
    assign irq = irq_r;
    assign alarm_trigger = alarm_r;
    assign fault_present = present_r;

endmodule

/* File: gdam_regs_chk.sv */
`timescale 1ns/10ps
`include "gdam_consts.svh"
module gdam_regs_chk #(
    parameter int NUM_PINS = 7
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // register port
    input gdam_pkg::gdam_reg_req_t reg_req,
    input logic [15:0] reg_rdata,
    input logic reg_rvalid,
    // pins
    input wire logic [NUM_PINS-1:0] pin_in,
    input gdam_pkg::gdam_pin_drv_t pin_drv,
    // alarm
    input wire logic [15:0] fault_status,
    input logic [15:0] alarm_mask,
    input logic irq,
    input logic alarm_trigger,
    input logic fault_present
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    // reads and mask writes
    sequence s_rd(a);
        reg_req.rd && reg_req.addr == a;
    endsequence
    sequence s_wr_mask;
        reg_req.wr && reg_req.addr == 8'h1d;
    endsequence
    AST_RVALID: assert property (reg_req.rd |=> reg_rvalid)
        else $error("read not answered");
    AST_NO_RVALID: assert property (!reg_req.rd |=> !reg_rvalid)
        else $error("answer without read");
    AST_PIN_RSV: assert property (s_rd(8'h1c) |=> reg_rdata[15:7] == 9'h0)
        else $error("pin data upper bits set");
    AST_MASK_RD: assert property (s_rd(8'h1d) |=> reg_rdata == $past(alarm_mask))
        else $error("mask read wrong");
    AST_MASK_WR: assert property (s_wr_mask |=> alarm_mask ==
        (($past(reg_req.wdata) & `GDAM_MASK_WR_BITS) | `GDAM_MASK_RSV_ONES))
        else $error("mask write wrong");
    AST_MASK_HOLD: assert property (!(reg_req.wr && reg_req.addr == 8'h1d)
        |=> $stable(alarm_mask)) else $error("mask changed without write");
    AST_MASK_RSV: assert property ((alarm_mask & 16'hce00) == 16'hce00)
        else $error("mask reserved bits wrong");
    AST_IRQ: assert property (1'b1 |=> irq ==
        |($past(fault_status) & ~$past(alarm_mask))) else $error("irq wrong");
    AST_ALARM: assert property (alarm_trigger == irq)
        else $error("alarm differs from irq");
    AST_PRESENT: assert property (1'b1 |=> fault_present ==
        |($past(fault_status) & `GDAM_MASK_WR_BITS)) else $error("fault present wrong");
endmodule
bind gdam_regs gdam_regs_chk #(.NUM_PINS(NUM_PINS)) u_chk (
    .clk_sys(clk_sys), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .pin_in(pin_in), .pin_drv(pin_drv),
    .fault_status(fault_status), .alarm_mask(alarm_mask), .irq(irq),
    .alarm_trigger(alarm_trigger), .fault_present(fault_present));

/* File: tb_top.sv */
`timescale 1ns/10ps
module tb_top;
    logic clk_sys;
    logic rst;
    gdam_pkg::gdam_reg_req_t req;
    gdam_pkg::gdam_pin_drv_t drv;
    logic [15:0] rdata, amask, fst;
    logic rvalid, irq, alrm, fpres;
    logic [6:0] pin_in;
    int mismatches, compares;
    int bl[11] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 12, 13};
    // block under test
    gdam_regs DUT (.clk_sys(clk_sys), .rst(rst), .reg_req(req), .reg_rdata(rdata),
        .reg_rvalid(rvalid), .pin_in(pin_in), .pin_drv(drv), .fault_status(fst),
        .alarm_mask(amask), .irq(irq), .alarm_trigger(alrm), .fault_present(fpres));
    // 200 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // value compare
    task chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // bus cycles and waits
    task wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge clk_sys) req <= '{a, v, 1'b1, 1'b0};
        @(posedge clk_sys) req <= '0;
    endtask
    task rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk_sys) req <= '{a, 16'h0, 1'b0, 1'b1};
        @(posedge clk_sys) req <= '0;
        @(negedge clk_sys);
        chk({15'h0, rvalid}, 16'h1);
        chk(rdata, e);
    endtask
    task fs(input logic [15:0] v);
        @(posedge clk_sys) fst <= v;
    endtask
    task w(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    // reset values
    task t_rst;
        rd(8'h1c, 16'h007f);
        rd(8'h1d, 16'hefdf);
        chk({9'h0, drv.oe_n}, 16'h007f);
        chk(amask, 16'hefdf);
        fs(16'h1000);
        w(2);
        chk({15'h0, irq}, 16'h1);
        fs(16'h0020);
        w(2);
        chk({15'h0, alrm}, 16'h1);
        fs(16'h0003);
        w(2);
        chk({15'h0, irq}, 16'h0);
        chk({15'h0, fpres}, 16'h1);
        fs(16'h0000);
    endtask
    // every mask bit gates its own fault only
    task t_mask;
        wr(8'h1d, 16'h0000);
        rd(8'h1d, 16'hce00);
        fs(16'hce00);
        w(2);
        chk({15'h0, irq}, 16'h0);
        chk({15'h0, fpres}, 16'h0);
        chk(amask, 16'hce00);
        foreach (bl[i]) begin
            wr(8'h1d, ~(16'h1 << bl[i]));
            fs(16'h1 << bl[i]);
            w(2);
            chk({15'h0, irq}, 16'h1);
            chk({15'h0, alrm}, 16'h1);
            fs(16'h3fff ^ (16'h1 << bl[i]));
            w(2);
            chk({15'h0, irq}, 16'h0);
            chk({15'h0, fpres}, 16'h1);
        end
        fs(16'h0);
    endtask
    // pin output, input and disable
    task t_pin;
        wr(8'h1b, 16'h7f00);
        wr(8'h1c, 16'hff55);
        w(1);
        chk({9'h0, drv.oe_n}, 16'h0000);
        chk({9'h0, drv.level}, 16'h0055);
        rd(8'h1c, 16'h0055);
        wr(8'h1b, 16'h7f7f);
        w(1);
        chk({9'h0, drv.oe_n}, 16'h0055);
        chk({9'h0, drv.level}, 16'h0000);
        @(posedge clk_sys) pin_in <= 7'h2a;
        wr(8'h1c, 16'h007f);
        w(4);
        rd(8'h1c, 16'h002a);
        wr(8'h1b, 16'h007f);
        w(1);
        chk({9'h0, drv.oe_n}, 16'h007f);
        rd(8'h1c, 16'h007f);
        wr(8'h1e, 16'h1234);
        rd(8'h1e, 16'h0000);
    endtask
    // verdict
    task results;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        rst = 1'b1;
        req = '0;
        fst = '0;
        pin_in = '0;
        mismatches = 0;
        compares = 0;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        t_rst;
        t_mask;
        t_pin;
        results;
    end
    // watchdog
    initial begin
        #20000;
        mismatches++;
        results;
    end
endmodule
